// [cvr_pkg.sv]
// constants, types and register map for the charger voltage configuration bank
package cvr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the serial target port (one byte per address)
  localparam logic [7:0] CVR_ADDR_VSYS = 8'h00; // min system voltage
  localparam logic [7:0] CVR_ADDR_CHARGE_VOLTAGE_TARGET_HI = 8'h01; // charge voltage bits 15-8
  localparam logic [7:0] CVR_ADDR_CHARGE_VOLTAGE_TARGET_LO = 8'h02; // charge voltage bits 7-0
  localparam logic [7:0] CVR_ADDR_DPLUS_HI = 8'h43; // d+ line adc result
  localparam logic [7:0] CVR_ADDR_DPLUS_LO = 8'h44;
  localparam logic [7:0] CVR_ADDR_DMINUS_HI = 8'h45; // d- line adc result
  localparam logic [7:0] CVR_ADDR_DMINUS_LO = 8'h46;
  localparam logic [7:0] CVR_ADDR_LINE_DRV = 8'h47; // usb line driver control
  localparam logic [7:0] CVR_ADDR_PART = 8'h48; // part info
  localparam logic [7:0] CVR_ADDR_CTRL = 8'h60; // register reset and sensed cells

  ////////////////////////////////////////////////////////////////////////////
  // field layout
  localparam int CVR_VSYS_W = 6; // min system voltage code width
  localparam int CVR_VSYS_RSV_LSB = 6; // reserved r/w bits 7-6
  localparam int CVR_CHARGE_VOLTAGE_TARGET_W = 11; // charge voltage code width
  localparam int CVR_CHARGE_VOLTAGE_TARGET_HI_W = 3; // code bits 10-8 in the upper byte
  localparam int CVR_CTRL_RST_BIT = 0; // write 1: reload defaults
  localparam int CVR_CTRL_CELL_LSB = 1; // sensed cells minus one, 2 bits

  ////////////////////////////////////////////////////////////////////////////
  // encodings, in millivolts
  localparam int CVR_VSYS_OFS_MV = 2500;
  localparam int CVR_VSYS_STEP_MV = 250;
  localparam int CVR_VSYS_MAX_MV = 16000;
  localparam int CVR_CHARGE_VOLTAGE_TARGET_STEP_MV = 10;
  localparam int CVR_CHARGE_VOLTAGE_TARGET_MIN_MV = 3000;
  localparam int CVR_CHARGE_VOLTAGE_TARGET_MAX_MV = 18800;
  localparam logic [5:0] CVR_VSYS_CODE_MAX =
    6'((CVR_VSYS_MAX_MV - CVR_VSYS_OFS_MV) / CVR_VSYS_STEP_MV);
  localparam logic [10:0] CVR_CHARGE_VOLTAGE_TARGET_CODE_MIN = 11'(CVR_CHARGE_VOLTAGE_TARGET_MIN_MV / CVR_CHARGE_VOLTAGE_TARGET_STEP_MV);
  localparam logic [10:0] CVR_CHARGE_VOLTAGE_TARGET_CODE_MAX = 11'(CVR_CHARGE_VOLTAGE_TARGET_MAX_MV / CVR_CHARGE_VOLTAGE_TARGET_STEP_MV);

  // power-on defaults per sensed cell count (index = cells - 1)
  localparam int CVR_VSYS_DEF_MV [4] = '{3500, 7000, 9000, 12000};
  localparam int CVR_CHARGE_VOLTAGE_TARGET_DEF_MV [4] = '{4200, 8400, 12600, 16800};

  ////////////////////////////////////////////////////////////////////////////
  // reset values and timing
  localparam logic [1:0] CVR_VSYS_RSV_RST = 2'h0;
  localparam logic [7:0] CVR_LINE_DRV_RST = 8'h00;
  localparam logic [1:0] CVR_CELLS_RST = 2'h0;
  localparam int CVR_STRAP_SETTLE_CYC = 4; // cycles before the strap is caught

  ////////////////////////////////////////////////////////////////////////////
  // serial target states, one-hot
  typedef enum logic [8:0] {
    CVR_ST_IDLE = 9'h001,
    CVR_ST_ADDR = 9'h002,
    CVR_ST_ADDR_ACK = 9'h004,
    CVR_ST_PTR = 9'h008,
    CVR_ST_PTR_ACK = 9'h010,
    CVR_ST_WDATA = 9'h020,
    CVR_ST_WDATA_ACK = 9'h040,
    CVR_ST_RDATA = 9'h080,
    CVR_ST_RACK = 9'h100
  } cvr_st_e;

  // configuration handed to the regulation logic
  typedef struct packed {
    logic [1:0] cells; // sensed cells minus one
    logic [5:0] vsys_min; // min system voltage code
    logic [10:0] charge_voltage_target; // charge voltage target code
  } cvr_cfg_s;

endpackage

// [cvr_cell_sense.sv]
// cell-count strap capture after reset and default code lookup
`timescale 1ns/100ps
`default_nettype none
module cvr_cell_sense #(
  parameter int SETTLE_CYC = cvr_pkg::CVR_STRAP_SETTLE_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] strap,
  output logic [1:0] cells,
  output logic [5:0] vsys_def,
  output logic [10:0] charge_voltage_target_def,
  output logic load,
  output logic done
);
  import cvr_pkg::*;

  localparam int CW = $clog2(SETTLE_CYC + 1);

  // refuse a settle time the counter cannot serve
  if (SETTLE_CYC < 1) begin : g_bad_settle
    $error("cvr_cell_sense: SETTLE_CYC must be at least 1");
  end

  logic [CW-1:0] cnt_q; // settle counter, stops once sensed
  logic [1:0] cells_q; // caught strap code
  logic done_q; // strap has been caught
  logic load_q; // one-cycle default load request
  logic capture; // last settle cycle

  assign capture = !done_q && (cnt_q == CW'(SETTLE_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////
  // settle counter: the strap divider needs time after power-on
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (!done_q && !capture) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // catch the strap once, after release; a port never feeds the reset branch
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cells_q <= CVR_CELLS_RST;
      done_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      load_q <= capture;
      if (capture) begin
        cells_q <= strap;
        done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // default codes from the caught count
  always_comb begin
    vsys_def = 6'((CVR_VSYS_DEF_MV[cells_q] - CVR_VSYS_OFS_MV) / CVR_VSYS_STEP_MV);
    charge_voltage_target_def = 11'(CVR_CHARGE_VOLTAGE_TARGET_DEF_MV[cells_q] / CVR_CHARGE_VOLTAGE_TARGET_STEP_MV);
  end

  assign cells = cells_q;
  assign load = load_q;
  assign done = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_cells_frozen: assert property (done_q |=> done_q && $stable(cells_q))
    else $error("sensed cell count changed after capture");
  a_load_with_sense: assert property ($rose(done_q) |-> load_q ##1 !load_q)
    else $error("default load not a single pulse at capture");

endmodule
`default_nettype wire

// [cvr_regs.sv]
// charger voltage configuration bank behind a two-wire serial target port
//
// Operation
// - clamped-low field: below-minimum writes are discarded
// - clamped-high field: above-maximum writes are discarded
// - only in-range codes are stored once the strap is caught
// - strap sensed after reset selects cell count
// - min system code bits 5-0, max 16000mV
// - min system default 3.5/7/9/12 V per cells
// - charge voltage code bits 10-0, min 3000mV
// - charge default 4.2/8.4/12.6/16.8 V per cells
`timescale 1ns/100ps
`default_nettype none
module cvr_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2A, // target address, value arbitrary
  parameter logic [7:0] PART_INFO = 8'h00, // part info readback, value arbitrary
  parameter int SETTLE_CYC = cvr_pkg::CVR_STRAP_SETTLE_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] cell_count_strap_pin,
  input wire logic [15:0] dplus_adc,
  input wire logic [15:0] dminus_adc,
  output logic [7:0] line_drv_ctrl,
  output cvr_pkg::cvr_cfg_s cfg,
  output logic cfg_valid
);
  import cvr_pkg::*;

  // the general-call address would collide with every target
  if (DEV_ADDR == 7'h00) begin : g_bad_addr
    $error("cvr_regs: DEV_ADDR must not be zero");
  end

  ////////////////////////////////////////////////////////////////////////////
  // line sampling and bus conditions
  logic scl_q, scl_p; // current and previous clock level
  logic sda_q, sda_p; // current and previous data level
  logic start_det, stop_det, scl_rise, scl_fall;

  // inputs are synchronous, one stage gives a clean previous value
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      scl_p <= 1'b1;
      sda_q <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_q <= scl;
      scl_p <= scl_q;
      sda_q <= sda_in;
      sda_p <= sda_q;
    end
  end

  assign start_det = scl_q && scl_p && sda_p && !sda_q;
  assign stop_det = scl_q && scl_p && !sda_p && sda_q;
  assign scl_rise = scl_q && !scl_p;
  assign scl_fall = !scl_q && scl_p;

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [5:0] vsys_q; // min system voltage code
  logic [1:0] vsys_rsv_q; // reserved r/w bits of the same byte
  logic [10:0] charge_voltage_target_q; // charge voltage target code
  logic [2:0] charge_voltage_target_hi_q; // staged upper byte, commits with the low byte
  logic [7:0] line_drv_q; // usb line driver control
  logic [1:0] cells; // sensed cells minus one
  logic [5:0] vsys_def;
  logic [10:0] charge_voltage_target_def;
  logic def_por_load; // pulse once the strap is caught
  logic sense_done;

  cvr_cell_sense #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_sense (
    .core_clk(core_clk),
    .resetn(resetn),
    .strap(cell_count_strap_pin),
    .cells(cells),
    .vsys_def(vsys_def),
    .charge_voltage_target_def(charge_voltage_target_def),
    .load(def_por_load),
    .done(sense_done)
  );

  // read view of every mapped byte; unmapped bytes read zero
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      CVR_ADDR_VSYS: r = {vsys_rsv_q, vsys_q};
      CVR_ADDR_CHARGE_VOLTAGE_TARGET_HI: r = {5'h00, charge_voltage_target_q[10:8]};
      CVR_ADDR_CHARGE_VOLTAGE_TARGET_LO: r = charge_voltage_target_q[7:0];
      CVR_ADDR_DPLUS_HI: r = dplus_adc[15:8];
      CVR_ADDR_DPLUS_LO: r = dplus_adc[7:0];
      CVR_ADDR_DMINUS_HI: r = dminus_adc[15:8];
      CVR_ADDR_DMINUS_LO: r = dminus_adc[7:0];
      CVR_ADDR_LINE_DRV: r = line_drv_q;
      CVR_ADDR_PART: r = PART_INFO;
      CVR_ADDR_CTRL: r = {5'h00, cells, 1'b0};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // serial target state machine
  cvr_st_e state_q;
  logic [3:0] bit_cnt_q; // bits clocked in the current byte
  logic [7:0] rx_q; // received byte
  logic [7:0] tx_q; // byte being sent, msb on the line
  logic [7:0] ptr_q; // register pointer, auto-increments
  logic rw_q; // 1: read transfer
  logic nack_q; // host acknowledge level after a read byte
  logic byte_end; // falling edge closing the eighth bit
  logic wr_en; // one-cycle register write strobe

  assign byte_end = scl_fall && (bit_cnt_q == 4'h8);
  assign wr_en = byte_end && (state_q == CVR_ST_WDATA);

  // start from any state restarts; stop always releases the bus
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= CVR_ST_IDLE;
      bit_cnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'hFF;
      rw_q <= 1'b0;
      nack_q <= 1'b1;
    end else if (stop_det) begin
      state_q <= CVR_ST_IDLE;
    end else if (start_det) begin
      state_q <= CVR_ST_ADDR;
      bit_cnt_q <= 4'h0;
    end else if (scl_rise) begin
      // shift in on the rising edge while a byte is in flight
      if (state_q inside {CVR_ST_ADDR, CVR_ST_PTR, CVR_ST_WDATA, CVR_ST_RDATA}) begin
        rx_q <= {rx_q[6:0], sda_q};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      if (state_q == CVR_ST_RACK) begin
        nack_q <= sda_q;
      end
    end else if (scl_fall) begin
      unique case (state_q)
        CVR_ST_IDLE: begin
        end
        CVR_ST_ADDR: begin
          // foreign address: stay off the bus until the next start
          if (byte_end) begin
            if (rx_q[7:1] == DEV_ADDR) begin
              state_q <= CVR_ST_ADDR_ACK;
              rw_q <= rx_q[0];
            end else begin
              state_q <= CVR_ST_IDLE;
            end
          end
        end
        CVR_ST_ADDR_ACK: begin
          bit_cnt_q <= 4'h0;
          if (rw_q) begin
            state_q <= CVR_ST_RDATA;
            tx_q <= rd_mux(ptr_q);
          end else begin
            state_q <= CVR_ST_PTR;
          end
        end
        CVR_ST_PTR: begin
          if (byte_end) begin
            state_q <= CVR_ST_PTR_ACK;
          end
        end
        CVR_ST_WDATA: begin
          if (byte_end) begin
            state_q <= CVR_ST_WDATA_ACK;
          end
        end
        CVR_ST_PTR_ACK, CVR_ST_WDATA_ACK: begin
          state_q <= CVR_ST_WDATA;
          bit_cnt_q <= 4'h0;
        end
        CVR_ST_RDATA: begin
          // release for the host acknowledge after the eighth bit
          if (byte_end) begin
            state_q <= CVR_ST_RACK;
          end else begin
            tx_q <= {tx_q[6:0], 1'b1};
          end
        end
        CVR_ST_RACK: begin
          if (!nack_q) begin
            state_q <= CVR_ST_RDATA;
            tx_q <= rd_mux(ptr_q);
            bit_cnt_q <= 4'h0;
          end else begin
            state_q <= CVR_ST_IDLE;
          end
        end
      endcase
    end
  end

  // pointer: set by the first written byte, then steps per data byte
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_q <= 8'h00;
    end else if (byte_end && state_q == CVR_ST_PTR && !start_det && !stop_det) begin
      ptr_q <= rx_q;
    end else if (wr_en || (byte_end && state_q == CVR_ST_RDATA)) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = (state_q inside {CVR_ST_ADDR_ACK, CVR_ST_PTR_ACK, CVR_ST_WDATA_ACK})
                  || (state_q == CVR_ST_RDATA && !tx_q[7]);

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  logic load_def; // power-on or software default reload
  logic [10:0] charge_voltage_target_cand; // staged upper byte joined with the low byte
  logic charge_voltage_target_ok; // candidate lies inside the legal range

  assign load_def = def_por_load
                    || (wr_en && ptr_q == CVR_ADDR_CTRL && rx_q[CVR_CTRL_RST_BIT]);
  assign charge_voltage_target_cand = {charge_voltage_target_hi_q, rx_q};
  // the high side is checked too, so no invalid code can reach regulation
  assign charge_voltage_target_ok = (charge_voltage_target_cand >= CVR_CHARGE_VOLTAGE_TARGET_CODE_MIN) && (charge_voltage_target_cand <= CVR_CHARGE_VOLTAGE_TARGET_CODE_MAX);

  // min system voltage: codes above the top of range leave the field alone
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vsys_q <= 6'h00;
    end else if (load_def) begin
      vsys_q <= vsys_def;
    end else if (wr_en && ptr_q == CVR_ADDR_VSYS && rx_q[5:0] <= CVR_VSYS_CODE_MAX) begin
      vsys_q <= rx_q[5:0];
    end
  end

  // reserved bits of the same byte store freely and survive register reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vsys_rsv_q <= CVR_VSYS_RSV_RST;
    end else if (wr_en && ptr_q == CVR_ADDR_VSYS) begin
      vsys_rsv_q <= rx_q[7:CVR_VSYS_RSV_LSB];
    end
  end

  // charge voltage: whole code commits on the low byte, so no torn value
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      charge_voltage_target_q <= 11'h000;
      charge_voltage_target_hi_q <= 3'h0;
    end else if (load_def) begin
      charge_voltage_target_q <= charge_voltage_target_def;
      charge_voltage_target_hi_q <= charge_voltage_target_def[10:8];
    end else if (wr_en && ptr_q == CVR_ADDR_CHARGE_VOLTAGE_TARGET_HI) begin
      charge_voltage_target_hi_q <= rx_q[CVR_CHARGE_VOLTAGE_TARGET_HI_W-1:0];
    end else if (wr_en && ptr_q == CVR_ADDR_CHARGE_VOLTAGE_TARGET_LO) begin
      if (charge_voltage_target_ok) begin
        charge_voltage_target_q <= charge_voltage_target_cand;
        charge_voltage_target_hi_q <= charge_voltage_target_cand[10:8];
      end else begin
        charge_voltage_target_hi_q <= charge_voltage_target_q[10:8];
      end
    end
  end

  // usb line driver control
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      line_drv_q <= CVR_LINE_DRV_RST;
    end else if (wr_en && ptr_q == CVR_ADDR_LINE_DRV) begin
      line_drv_q <= rx_q;
    end
  end

  assign line_drv_ctrl = line_drv_q;
  assign cfg = '{cells: cells, vsys_min: vsys_q, charge_voltage_target: charge_voltage_target_q};
  assign cfg_valid = sense_done;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_vsys_high_drop: assert property (
    wr_en && ptr_q == CVR_ADDR_VSYS && rx_q[5:0] > CVR_VSYS_CODE_MAX && !load_def
    |=> $stable(vsys_q))
    else $error("above-range min system write was stored");
  a_vsys_take: assert property (
    wr_en && ptr_q == CVR_ADDR_VSYS && rx_q[5:0] <= CVR_VSYS_CODE_MAX && !load_def
    |=> vsys_q == $past(rx_q[5:0]))
    else $error("in-range min system write not stored");
  a_charge_voltage_target_low_drop: assert property (
    wr_en && ptr_q == CVR_ADDR_CHARGE_VOLTAGE_TARGET_LO && charge_voltage_target_cand < CVR_CHARGE_VOLTAGE_TARGET_CODE_MIN && !load_def
    |=> $stable(charge_voltage_target_q))
    else $error("below-range charge voltage write was stored");
  a_charge_voltage_target_take: assert property (
    wr_en && ptr_q == CVR_ADDR_CHARGE_VOLTAGE_TARGET_LO && charge_voltage_target_ok && !load_def
    |=> charge_voltage_target_q == $past(charge_voltage_target_cand) ##1 $stable(charge_voltage_target_q) || load_def)
    else $error("in-range charge voltage write not stored");
  a_codes_in_range: assert property (
    sense_done && !def_por_load |-> vsys_q <= CVR_VSYS_CODE_MAX
    && charge_voltage_target_q >= CVR_CHARGE_VOLTAGE_TARGET_CODE_MIN && charge_voltage_target_q <= CVR_CHARGE_VOLTAGE_TARGET_CODE_MAX)
    else $error("field holds an out-of-range code");
  a_por_defaults: assert property (
    def_por_load |=> vsys_q == $past(vsys_def) && charge_voltage_target_q == $past(charge_voltage_target_def))
    else $error("power-on defaults not loaded");
  a_regrst_defaults: assert property (
    wr_en && ptr_q == CVR_ADDR_CTRL && rx_q[CVR_CTRL_RST_BIT]
    |=> vsys_q == vsys_def && charge_voltage_target_q == charge_voltage_target_def)
    else $error("register reset did not restore defaults");
  a_resv_zero: assert property (state_q == CVR_ST_RDATA && ptr_q == CVR_ADDR_CHARGE_VOLTAGE_TARGET_HI
    && bit_cnt_q == 4'h0 |-> tx_q[7:3] == 5'h00) else $error("reserved bits read nonzero");
  a_ack_drive: assert property (
    scl_fall && state_q == CVR_ST_ADDR && byte_end && rx_q[7:1] == DEV_ADDR
    && !start_det && !stop_det |=> sda_oe [*1] ##1 $stable(sda_oe))
    else $error("address match not acknowledged");

  c_por_load: cover property (def_por_load ##1 cfg_valid);
  c_charge_voltage_target_commit: cover property (wr_en && ptr_q == CVR_ADDR_CHARGE_VOLTAGE_TARGET_LO && charge_voltage_target_ok);
  c_charge_voltage_target_reject: cover property (wr_en && ptr_q == CVR_ADDR_CHARGE_VOLTAGE_TARGET_LO && !charge_voltage_target_ok);
  c_read_byte: cover property (state_q == CVR_ST_RDATA ##[1:1000] state_q == CVR_ST_RACK);

endmodule
`default_nettype wire

// [cvr_host.sv]
// two-wire host model that drives the bank's serial port
`timescale 1ns/100ps
`default_nettype none
module cvr_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2A, // must match the target
  parameter int HALF = 4 // scl phase length in core clocks
) (
  input wire logic core_clk,
  output logic scl,
  output logic sda_pull, // high: host pulls sda low
  input wire logic sda
);
  logic ack_ok; // every byte the host sent in the last transfer was acked
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // line level, every change lands just after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // data moves two clocks after scl fell, never under a high clock
  task automatic bit9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      tick(2);
      sda_pull = ~tx[i];
      tick(HALF);
      scl = 1'b1;
      tick(HALF);
      rx[i] = sda;
      scl = 1'b0;
    end
  endtask
  // start, or repeated start from a low clock
  task automatic start();
    tick(2);
    sda_pull = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_pull = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_pull = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_pull = 1'b0;
    tick(HALF);
  endtask
  ////////////////////////////////////////////////////////////
  // byte level, data released in the ack slot
  task automatic send(input logic [7:0] b);
    logic [8:0] r;
    bit9({b, 1'b1}, r);
    ack_ok = ack_ok & ~r[0];
  endtask
  task automatic head(input logic [7:0] ptr);
    ack_ok = 1'b1;
    start();
    send({DEV_ADDR, 1'b0});
    send(ptr);
  endtask
  task automatic wr8(input logic [7:0] ptr, input logic [7:0] d);
    head(ptr);
    send(d);
    stop();
  endtask
  // write aimed at another target: no byte may be acked
  task automatic wr8_other(input logic [6:0] a, input logic [7:0] ptr, input logic [7:0] d);
    ack_ok = 1'b1;
    start();
    send({a, 1'b0});
    send(ptr);
    send(d);
    stop();
  endtask
  // high byte first, so the committing low byte lands last
  task automatic wr16(input logic [7:0] ptr, input logic [15:0] d);
    head(ptr);
    send(d[15:8]);
    send(d[7:0]);
    stop();
  endtask
  // pointer, repeated start, two bytes back, nack on the last
  task automatic rd16(input logic [7:0] ptr, output logic [15:0] d);
    logic [8:0] r;
    head(ptr);
    start();
    send({DEV_ADDR, 1'b1});
    bit9({8'hFF, 1'b0}, r);
    d[15:8] = r[8:1];
    bit9({8'hFF, 1'b1}, r);
    d[7:0] = r[8:1];
    stop();
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the charger voltage configuration bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cvr_pkg::*;
  localparam int SETTLE = 2; // short strap settle count
  localparam logic [6:0] ADDR = 7'h2A; // target address, value arbitrary
  localparam logic [15:0] DP_VAL = 16'h1234; // adc patterns read back
  localparam logic [15:0] DM_VAL = 16'hBEEF;
  // one row per strap code with its default voltages in mV
  typedef struct {
    logic [1:0] strap;
    int vsys_mv;
    int charge_voltage_target_mv;
  } cvr_row_s;
  cvr_row_s rows [4] = '{'{2'h0, 3500, 4200}, '{2'h1, 7000, 8400},
    '{2'h2, 9000, 12600}, '{2'h3, 12000, 16800}};
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [15:0] dplus_adc = DP_VAL;
  logic [15:0] dminus_adc = DM_VAL;
  logic scl;
  logic host_pull;
  logic sda_out;
  logic sda_oe;
  logic [7:0] line_drv_ctrl;
  cvr_cfg_s cfg;
  logic cfg_valid;
  wire logic sda_line;
  logic [15:0] rd;
  logic [15:0] vs;
  logic [15:0] vr;
  int err_count = 0;
  int num_checks = 0;
  always #4 core_clk = ~core_clk; // 125 MHz
  // pulled-up wire, low while either party pulls
  assign sda_line = host_pull ? 1'b0 : (sda_oe ? sda_out : 1'b1);
  cvr_regs #(.DEV_ADDR(ADDR), .SETTLE_CYC(SETTLE)) cvr_regs_inst (
    .core_clk(core_clk), .resetn(resetn), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .cell_count_strap_pin(strap),
    .dplus_adc(dplus_adc), .dminus_adc(dminus_adc), .line_drv_ctrl(line_drv_ctrl),
    .cfg(cfg), .cfg_valid(cfg_valid));
  cvr_host #(.DEV_ADDR(ADDR)) cvr_host_inst (
    .core_clk(core_clk), .scl(scl), .sda_pull(host_pull), .sda(sda_line));
  ////////////////////////////////////////////////////////////
  // comparison and closing
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // strap is held from reset until well past capture
  task automatic do_reset(input logic [1:0] s);
    resetn = 1'b0;
    strap = s;
    repeat (12) @(posedge core_clk);
    #1;
    chk_val({8'h00, line_drv_ctrl}, 16'h0000);
    chk_val(16'(cfg_valid), 16'h0000);
    resetn = 1'b1;
    repeat (SETTLE + 3) @(posedge core_clk);
    #1;
    chk_val(16'(cfg_valid), 16'h0001);
  endtask
  // write, expect an ack even when discarded, then read back
  task automatic try_vsys(input logic [7:0] d, input logic [7:0] exp);
    cvr_host_inst.wr8(CVR_ADDR_VSYS, d);
    chk_val(16'(cvr_host_inst.ack_ok), 16'h0001);
    cvr_host_inst.rd16(CVR_ADDR_VSYS, rd);
    chk_val({8'h00, rd[15:8]}, {8'h00, exp});
    chk_val(16'(cfg.vsys_min), 16'(exp[5:0]));
  endtask
  task automatic try_charge_voltage_target(input logic [15:0] d, input logic [15:0] exp);
    cvr_host_inst.wr16(CVR_ADDR_CHARGE_VOLTAGE_TARGET_HI, d);
    chk_val(16'(cvr_host_inst.ack_ok), 16'h0001);
    cvr_host_inst.rd16(CVR_ADDR_CHARGE_VOLTAGE_TARGET_HI, rd);
    chk_val(rd, exp);
    chk_val(16'(cfg.charge_voltage_target), 16'(exp[10:0]));
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence: strap table, then the awkward cases
  initial begin
    foreach (rows[i]) begin
      do_reset(rows[i].strap);
      vs = 16'((rows[i].vsys_mv - CVR_VSYS_OFS_MV) / CVR_VSYS_STEP_MV);
      vr = 16'(rows[i].charge_voltage_target_mv / CVR_CHARGE_VOLTAGE_TARGET_STEP_MV);
      chk_val(16'(cfg.cells), 16'(rows[i].strap));
      chk_val(16'(cfg.vsys_min), vs);
      chk_val(16'(cfg.charge_voltage_target), vr);
      cvr_host_inst.rd16(CVR_ADDR_CHARGE_VOLTAGE_TARGET_HI, rd);
      chk_val(rd, vr);
      cvr_host_inst.rd16(CVR_ADDR_CTRL, rd);
      chk_val(rd, {5'h00, rows[i].strap, 9'h000});
    end
    // min system code: top 16000mV is code 54, no low clamp
    try_vsys(8'h36, 8'h36);
    try_vsys(8'h37, 8'h36);
    try_vsys(8'h3F, 8'h36);
    try_vsys(8'h00, 8'h00);
    try_vsys(8'hC5, 8'hC5);
    // charge code: 3000mV is 300, 18800mV is 1880
    try_charge_voltage_target(16'd300, 16'd300);
    try_charge_voltage_target(16'd299, 16'd300);
    try_charge_voltage_target(16'd1880, 16'd1880);
    try_charge_voltage_target(16'd1881, 16'd1880);
    try_charge_voltage_target(16'hF9F4, 16'h01F4);
    try_charge_voltage_target(16'h0000, 16'h01F4);
    // register reset back to the four-cell defaults
    cvr_host_inst.wr8(CVR_ADDR_CTRL, 8'h01);
    chk_val(16'(cfg.vsys_min), vs);
    chk_val(16'(cfg.charge_voltage_target), vr);
    cvr_host_inst.rd16(CVR_ADDR_CHARGE_VOLTAGE_TARGET_HI, rd);
    chk_val(rd, vr);
    // plain registers, adc readback and an unmapped pair
    cvr_host_inst.wr8(CVR_ADDR_LINE_DRV, 8'hA5);
    chk_val({8'h00, line_drv_ctrl}, 16'h00A5);
    // foreign target address: no ack and nothing stored
    cvr_host_inst.wr8_other(ADDR ^ 7'h01, CVR_ADDR_LINE_DRV, 8'h5A);
    chk_val(16'(cvr_host_inst.ack_ok), 16'h0000);
    chk_val({8'h00, line_drv_ctrl}, 16'h00A5);
    cvr_host_inst.rd16(CVR_ADDR_DPLUS_HI, rd);
    chk_val(rd, DP_VAL);
    cvr_host_inst.rd16(CVR_ADDR_DMINUS_HI, rd);
    chk_val(rd, DM_VAL);
    cvr_host_inst.rd16(8'h03, rd);
    chk_val(rd, 16'h0000);
    // second power-on, two cells: code 18, charge 840 high bits 3
    do_reset(2'h1);
    cvr_host_inst.rd16(CVR_ADDR_VSYS, rd);
    chk_val(rd, 16'h1203);
    end_sim();
  end
  // watchdog, well beyond the expected run length
  initial begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
